//--- frs_ramp_shaper.sv
// module: frequency ramp shaper with AXI4-Lite register file
// Summary of operation
// - per-direction shape code, linear to elevator S
// - per-direction curvature for S, U, inverted U
// - elevator start and end ratios, sum capped
// - all ratios 50 percent gives S profile
// - a 100 percent end ratio gives U profile, a 100 percent start ratio inverted U
// - elevator profile has straight middle portion
// - command, time or hold change recalculates curve
// - each fluctuation of the fmax-capped command restarts curve calculation
// - bypass input makes output follow command
// - bypass works for every command source
// - multi-speed command selects ramp times
// - multi-stage scheme disables two-stage time switching
// - zero to maximum takes exactly set time
// - hold input freezes ramp, release resumes
//
// Chosen here: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
module frs_ramp_shaper #(
  parameter int NUM_SPEEDS = 16,
  parameter longint unsigned TIME_UNIT_CYCLES = frs_pkg::CYC_PER_TIME_UNIT
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire frs_pkg::frs_axi_req_t axi_req,
  output frs_pkg::frs_axi_rsp_t axi_rsp,
  // command and terminals
  input wire logic [frs_pkg::FW-1:0] freq_cmd_in,
  input wire logic ramp_hold_input,
  input wire logic ramp_bypass_input,
  input wire logic two_stage_input,
  input wire logic [3:0] speed_select,
  input wire logic [6:0] speed_bits,
  // motor stage
  output logic [frs_pkg::FW-1:0] freq_out,
  output logic ramping,
  output logic decelerating
);
  import frs_pkg::*;

  if (NUM_SPEEDS < 8 || NUM_SPEEDS > 16)
  begin : g_chk
    $error("NUM_SPEEDS must lie in 8..16");
  end

  typedef enum {ST_LOADP, ST_DIVP, ST_LOADS, ST_DIVS, ST_APPLY} frs_st_t;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic is_spd(logic [AW-1:0] a);
    return a >= ADDR_SPD_BASE && a[1:0] == 2'h0 &&
      int'((a - ADDR_SPD_BASE) >> 2) < NUM_SPEEDS;
  endfunction

  function automatic logic [3:0] spd_index(logic [AW-1:0] a);
    logic [AW-1:0] d;
    d = (a - ADDR_SPD_BASE) >> 2;
    return d[3:0];
  endfunction

  function automatic logic [31:0] merge(logic [31:0] o, logic [31:0] d,
                                        logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++)
      if (s[i])
        r[8*i+:8] = d[8*i+:8];
    return r;
  endfunction

  function automatic logic [31:0] fix_ratio(logic [31:0] v);
    logic [6:0] st;
    logic [6:0] en;
    st = v[RATIO_W-1:0] > RATIO_MAX ? RATIO_MAX : v[RATIO_W-1:0];
    en = v[ELS_END_LSB+:RATIO_W];
    if (en > RATIO_MAX - st)
      en = RATIO_MAX - st;
    return {16'h0000, 1'b0, en, 1'b0, st};
  endfunction

  function automatic logic [3:0] clamp_curv(logic [3:0] k);
    return k < CURV_MIN ? CURV_MIN : (k > CURV_MAX ? CURV_MAX : k);
  endfunction

  // ---------------------------------------------------------------
  // bus slave
  // ---------------------------------------------------------------
  logic aw_held_reg, aw_held_next, w_held_reg, w_held_next;
  logic [AW-1:0] awaddr_reg, awaddr_next;
  logic [31:0] wdata_reg, wdata_next;
  logic [3:0] wstrb_reg, wstrb_next;
  logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
  logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next, rd_data;
  logic rd_ok, wr_ok, wr_en;
  logic [31:0] ctrl_reg, ctrl_next, curve_reg, curve_next;
  logic [31:0] els_acc_reg, els_acc_next, els_dec_reg, els_dec_next;
  logic [31:0] cmd_reg, cmd_next, fmax_reg, fmax_next;
  logic [31:0] tbase_reg, tbase_next, talt_reg, talt_next;
  logic [31:0] spd_reg [NUM_SPEEDS];
  logic [31:0] spd_next [NUM_SPEEDS];
  logic [FW-1:0] out_reg, out_next;
  logic [FW-1:0] len_reg, len_next;
  logic up_reg, up_next;

  assign axi_rsp.awready = !aw_held_reg && !bvalid_reg;
  assign axi_rsp.wready = !w_held_reg && !bvalid_reg;
  assign axi_rsp.bvalid = bvalid_reg;
  assign axi_rsp.bresp = bresp_reg;
  assign axi_rsp.arready = !rvalid_reg;
  assign axi_rsp.rvalid = rvalid_reg;
  assign axi_rsp.rdata = rdata_reg;
  assign axi_rsp.rresp = rresp_reg;

  always_comb
  begin
    rd_ok = 1'b1;
    rd_data = 32'h0000_0000;
    case (axi_req.araddr)
      ADDR_CTRL: rd_data = ctrl_reg;
      ADDR_CURVE: rd_data = curve_reg;
      ADDR_ELS_ACC: rd_data = els_acc_reg;
      ADDR_ELS_DEC: rd_data = els_dec_reg;
      ADDR_CMD: rd_data = cmd_reg;
      ADDR_FMAX: rd_data = fmax_reg;
      ADDR_TIME_BASE: rd_data = tbase_reg;
      ADDR_TIME_ALT: rd_data = talt_reg;
      ADDR_STATUS:
      begin
        rd_data[FW-1:0] = out_reg;
        rd_data[STAT_RAMP_BIT] = len_reg != '0;
        rd_data[STAT_HOLD_BIT] = ramp_hold_input;
        rd_data[STAT_BYP_BIT] = ramp_bypass_input;
        rd_data[STAT_DEC_BIT] = len_reg != '0 && !up_reg;
      end
      default:
        if (is_spd(axi_req.araddr))
          rd_data = spd_reg[spd_index(axi_req.araddr)];
        else
          rd_ok = 1'b0;
    endcase
    wr_ok = is_spd(awaddr_reg) || (awaddr_reg <= ADDR_TIME_ALT &&
      awaddr_reg[1:0] == 2'h0);
  end

  always_comb
  begin
    aw_held_next = aw_held_reg;
    w_held_next = w_held_reg;
    awaddr_next = awaddr_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    wr_en = 1'b0;
    if (axi_req.awvalid && axi_rsp.awready)
    begin
      aw_held_next = 1'b1;
      awaddr_next = axi_req.awaddr;
    end
    if (axi_req.wvalid && axi_rsp.wready)
    begin
      w_held_next = 1'b1;
      wdata_next = axi_req.wdata;
      wstrb_next = axi_req.wstrb;
    end
    if (aw_held_reg && w_held_reg && !bvalid_reg)
    begin
      wr_en = wr_ok;
      aw_held_next = 1'b0;
      w_held_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = wr_ok ? RESP_OKAY : RESP_SLVERR;
    end
    if (bvalid_reg && axi_req.bready)
      bvalid_next = 1'b0;
    if (axi_req.arvalid && axi_rsp.arready)
    begin
      rvalid_next = 1'b1;
      rdata_next = rd_data;
      rresp_next = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
    if (rvalid_reg && axi_req.rready)
      rvalid_next = 1'b0;
  end

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  always_comb
  begin
    ctrl_next = ctrl_reg;
    curve_next = curve_reg;
    els_acc_next = els_acc_reg;
    els_dec_next = els_dec_reg;
    cmd_next = cmd_reg;
    fmax_next = fmax_reg;
    tbase_next = tbase_reg;
    talt_next = talt_reg;
    spd_next = spd_reg;
    if (wr_en)
      case (awaddr_reg)
        ADDR_CTRL: ctrl_next = merge(ctrl_reg, wdata_reg, wstrb_reg) &
          CTRL_MASK;
        ADDR_CURVE:
        begin
          curve_next = merge(curve_reg, wdata_reg, wstrb_reg);
          curve_next = {16'h0000, 4'h0,
            clamp_curv(curve_next[CURVE_DEC_LSB+:CURV_W]), 4'h0,
            clamp_curv(curve_next[CURV_W-1:0])};
        end
        ADDR_ELS_ACC: els_acc_next =
          fix_ratio(merge(els_acc_reg, wdata_reg, wstrb_reg));
        ADDR_ELS_DEC: els_dec_next =
          fix_ratio(merge(els_dec_reg, wdata_reg, wstrb_reg));
        ADDR_CMD: cmd_next = {16'h0000,
          FW'(merge(cmd_reg, wdata_reg, wstrb_reg))};
        ADDR_FMAX: fmax_next = {16'h0000,
          FW'(merge(fmax_reg, wdata_reg, wstrb_reg))};
        ADDR_TIME_BASE: tbase_next = merge(tbase_reg, wdata_reg, wstrb_reg);
        ADDR_TIME_ALT: talt_next = merge(talt_reg, wdata_reg, wstrb_reg);
        default: spd_next[spd_index(awaddr_reg)] =
          merge(spd_reg[spd_index(awaddr_reg)], wdata_reg, wstrb_reg);
      endcase
  end

  // ---------------------------------------------------------------
  // ramp engine
  // ---------------------------------------------------------------
  frs_st_t st_reg, st_next;
  logic [FW-1:0] f0_reg, f0_next, x_reg, x_next, tgt_reg, tgt_next;
  logic [FW-1:0] time_reg, time_next, target, tgt_raw, cur_time;
  logic [47:0] acc_reg, acc_next, thr;
  logic hold_q_reg, hold_q_next, restart, dir_up;
  logic [4:0] cnt_reg, cnt_next;
  logic [23:0] rem_reg, rem_next, den_reg, den_next, rem_s;
  logic [17:0] q_reg, q_next, q_s, m;
  logic [16:0] p_reg, p_next, a_q, b_q, w, s, base_sel;
  logic [1:0] seg_reg, seg_next;
  logic [3:0] idx, curv;
  logic [31:0] sel_time, els;
  logic [33:0] pp, rr;
  logic [34:0] prod;
  logic signed [39:0] sm, blend;
  frs_shape_t shape;

  always_comb
  begin
    idx = speed_select;
    if (ctrl_reg[CTRL_BITMODE_BIT])
    begin
      idx = 4'h0;
      for (int i = 0; i < 7; i++)
        if (speed_bits[i])
          idx = 4'(i + 1);
    end
    sel_time = two_stage_input ? talt_reg : tbase_reg;
    if (ctrl_reg[CTRL_SCHEME_BIT])
      sel_time = int'(idx) < NUM_SPEEDS ? spd_reg[idx] : spd_reg[0];
    tgt_raw = ctrl_reg[CTRL_SRC_BIT] ? freq_cmd_in : cmd_reg[FW-1:0];
    target = tgt_raw > fmax_reg[FW-1:0] ? fmax_reg[FW-1:0] : tgt_raw;
    dir_up = target > out_reg;
    cur_time = dir_up ? sel_time[FW-1:0] : sel_time[TIME_DEC_LSB+:FW];
    // rate is fmax per set time, so any span scales exactly
    thr = 48'(time_reg) * 48'(TIME_UNIT_CYCLES);
    shape = frs_shape_t'(up_reg ? ctrl_reg[CTRL_ACC_LSB+:SHAPE_W] :
      ctrl_reg[CTRL_DEC_LSB+:SHAPE_W]);
    curv = up_reg ? curve_reg[CURV_W-1:0] : curve_reg[CURVE_DEC_LSB+:CURV_W];
    w = 17'(curv * CURV_STEP) > ONE ? ONE : 17'(curv * CURV_STEP);
    els = up_reg ? els_acc_reg : els_dec_reg;
    a_q = 17'(els[RATIO_W-1:0] * PCT_Q16);
    b_q = 17'(els[ELS_END_LSB+:RATIO_W] * PCT_Q16);
    m = TWO - 18'(a_q) - 18'(b_q);
    pp = p_reg * p_reg;
    rr = (ONE - p_reg) * (ONE - p_reg);
    // shared restoring divider, one quotient bit per cycle
    rem_s = rem_reg >= den_reg ? (rem_reg - den_reg) << 1 : rem_reg << 1;
    q_s = {q_reg[16:0], rem_reg >= den_reg};
    // S, U and inverted U bend towards their base curve by curvature
    sm = 40'(3 * pp[32:16]) - 40'(2 * 34'(34'(pp[32:16] * p_reg) >> 16));
    base_sel = shape == FRS_INV_U ? pp[32:16] :
      17'(2 * 18'(p_reg) - 18'(pp[32:16]));
    if (shape != FRS_S)
      sm = 40'(base_sel);
    // kept signed: curves below the diagonal pull the blend downwards
    blend = $signed(40'(p_reg)) +
      (($signed(40'(w)) * (sm - $signed(40'(p_reg)))) >>> 16);
    s = blend < 0 ? 17'h0 : (blend > 40'(ONE) ? ONE : blend[16:0]);
    if (shape == FRS_LINEAR)
      s = p_reg;
    if (shape == FRS_ELEV)
    begin
      s = q_reg > 18'(ONE) ? ONE : q_reg[16:0];
      if (seg_reg == 2'h2)
        s = ONE - s;
    end
    prod = 35'(len_reg * s) >> 16;
    restart = ramp_bypass_input || target != tgt_reg ||
      cur_time != time_reg || ramp_hold_input != hold_q_reg;
    out_next = out_reg;
    f0_next = f0_reg;
    len_next = len_reg;
    x_next = x_reg;
    acc_next = acc_reg;
    tgt_next = tgt_reg;
    time_next = time_reg;
    up_next = up_reg;
    hold_q_next = hold_q_reg;
    st_next = st_reg;
    cnt_next = cnt_reg;
    rem_next = rem_reg;
    den_next = den_reg;
    q_next = q_reg;
    p_next = p_reg;
    seg_next = seg_reg;
    if (restart)
    begin
      // a new command value alone is enough to start over
      tgt_next = target;
      f0_next = out_reg;
      time_next = cur_time;
      up_next = dir_up;
      hold_q_next = ramp_hold_input;
      x_next = '0;
      acc_next = '0;
      st_next = ST_LOADP;
      len_next = dir_up ? target - out_reg : out_reg - target;
      if (ramp_bypass_input)
      begin
        out_next = target;
        len_next = '0;
      end
    end
    else
    begin
      if (!ramp_hold_input && len_reg != '0)
      begin
        if (x_reg >= len_reg || thr == '0)
        begin
          out_next = tgt_reg;
          len_next = '0;
        end
        else if (acc_reg + 48'(fmax_reg) >= thr)
        begin
          acc_next = acc_reg + 48'(fmax_reg) - thr;
          x_next = x_reg + 1'b1;
        end
        else
          acc_next = acc_reg + 48'(fmax_reg);
      end
      unique case (st_reg)
        ST_LOADP:
        begin
          rem_next = 24'(x_reg);
          den_next = len_reg == '0 ? 24'h00_0001 : 24'(len_reg);
          q_next = '0;
          cnt_next = DIV_STEPS;
          st_next = ST_DIVP;
        end
        ST_DIVP, ST_DIVS:
        begin
          rem_next = rem_s;
          q_next = q_s;
          cnt_next = cnt_reg - 1'b1;
          if (cnt_reg == 5'h01)
          begin
            p_next = q_s > 18'(ONE) ? ONE : q_s[16:0];
            st_next = st_reg == ST_DIVP ? ST_LOADS : ST_APPLY;
          end
        end
        ST_LOADS:
        begin
          st_next = ST_APPLY;
          if (shape == FRS_ELEV)
          begin
            // equal halves reduce to S, a full end ratio to U, a full start ratio to inverted U
            st_next = ST_DIVS;
            q_next = '0;
            cnt_next = DIV_STEPS;
            if (p_reg < a_q)
            begin
              seg_next = 2'h0;
              rem_next = 24'(pp[33:16]);
              den_next = 24'(35'(a_q * m) >> 16);
            end
            else if (p_reg > ONE - b_q)
            begin
              seg_next = 2'h2;
              rem_next = 24'(rr[33:16]);
              den_next = 24'(35'(b_q * m) >> 16);
            end
            else
            begin
              seg_next = 2'h1;
              rem_next = 24'(2 * 18'(p_reg) - 18'(a_q));
              den_next = 24'(m);
            end
            if (den_next == '0)
              den_next = 24'h00_0001;
          end
        end
        ST_APPLY:
        begin
          st_next = ST_LOADP;
          if (!ramp_hold_input && len_reg != '0 && x_reg < len_reg)
            out_next = up_reg ? f0_reg + prod[FW-1:0] :
              f0_reg - prod[FW-1:0];
        end
      endcase
    end
  end

  assign freq_out = out_reg;
  assign ramping = len_reg != '0;
  assign decelerating = len_reg != '0 && !up_reg;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      {aw_held_reg, w_held_reg, bvalid_reg, rvalid_reg} <= 4'h0;
      awaddr_reg <= '0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
      bresp_reg <= RESP_OKAY;
      rresp_reg <= RESP_OKAY;
      rdata_reg <= '0;
      ctrl_reg <= CTRL_RST;
      curve_reg <= CURVE_RST;
      els_acc_reg <= ELS_RST;
      els_dec_reg <= ELS_RST;
      cmd_reg <= CMD_RST;
      fmax_reg <= FMAX_RST;
      tbase_reg <= TIME_RST;
      talt_reg <= TIME_RST;
      for (int i = 0; i < NUM_SPEEDS; i++)
        spd_reg[i] <= TIME_RST;
      {out_reg, f0_reg, len_reg, x_reg, tgt_reg} <= '0;
      time_reg <= TIME_RST[FW-1:0];
      acc_reg <= '0;
      {up_reg, hold_q_reg} <= 2'h0;
      st_reg <= ST_LOADP;
      cnt_reg <= '0;
      {rem_reg, den_reg} <= '0;
      q_reg <= '0;
      p_reg <= '0;
      seg_reg <= '0;
    end
    else
    begin
      {aw_held_reg, w_held_reg, bvalid_reg, rvalid_reg} <=
        {aw_held_next, w_held_next, bvalid_next, rvalid_next};
      awaddr_reg <= awaddr_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      bresp_reg <= bresp_next;
      rresp_reg <= rresp_next;
      rdata_reg <= rdata_next;
      ctrl_reg <= ctrl_next;
      curve_reg <= curve_next;
      els_acc_reg <= els_acc_next;
      els_dec_reg <= els_dec_next;
      cmd_reg <= cmd_next;
      fmax_reg <= fmax_next;
      tbase_reg <= tbase_next;
      talt_reg <= talt_next;
      spd_reg <= spd_next;
      {out_reg, f0_reg, len_reg, x_reg, tgt_reg} <=
        {out_next, f0_next, len_next, x_next, tgt_next};
      time_reg <= time_next;
      acc_reg <= acc_next;
      {up_reg, hold_q_reg} <= {up_next, hold_q_next};
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      {rem_reg, den_reg} <= {rem_next, den_next};
      q_reg <= q_next;
      p_reg <= p_next;
      seg_reg <= seg_next;
    end
  end
endmodule

//--- frs_pkg.sv
// package: constants, codes and bus carriers of the frequency ramp shaper
package frs_pkg;
  localparam int FW = 16;
  localparam int AW = 8;
  localparam longint unsigned CLK_HZ = 200_000_000;
  localparam longint unsigned TIME_UNIT_MS = 100;
  localparam longint unsigned CYC_PER_TIME_UNIT = CLK_HZ / 1000 * TIME_UNIT_MS;
  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [AW-1:0] ADDR_CTRL = 8'h00;
  localparam logic [AW-1:0] ADDR_CURVE = 8'h04;
  localparam logic [AW-1:0] ADDR_ELS_ACC = 8'h08;
  localparam logic [AW-1:0] ADDR_ELS_DEC = 8'h0C;
  localparam logic [AW-1:0] ADDR_CMD = 8'h10;
  localparam logic [AW-1:0] ADDR_FMAX = 8'h14;
  localparam logic [AW-1:0] ADDR_TIME_BASE = 8'h18;
  localparam logic [AW-1:0] ADDR_TIME_ALT = 8'h1C;
  localparam logic [AW-1:0] ADDR_STATUS = 8'h20;
  localparam logic [AW-1:0] ADDR_SPD_BASE = 8'h40;
  // ---------------------------------------------------------------
  // fields and reset values
  // ---------------------------------------------------------------
  localparam int CTRL_ACC_LSB = 0;
  localparam int CTRL_DEC_LSB = 4;
  localparam int CTRL_SCHEME_BIT = 8;
  localparam int CTRL_SRC_BIT = 9;
  localparam int CTRL_BITMODE_BIT = 10;
  localparam int SHAPE_W = 3;
  localparam int CURV_W = 4;
  localparam int CURVE_DEC_LSB = 8;
  localparam int RATIO_W = 7;
  localparam int ELS_END_LSB = 8;
  localparam int TIME_DEC_LSB = 16;
  localparam int STAT_RAMP_BIT = 16;
  localparam int STAT_HOLD_BIT = 17;
  localparam int STAT_BYP_BIT = 18;
  localparam int STAT_DEC_BIT = 19;
  localparam logic [31:0] CTRL_MASK = 32'h0000_0777;
  localparam logic [31:0] CTRL_RST = 32'h0000_0011;
  localparam logic [31:0] CURVE_RST = 32'h0000_0202;
  localparam logic [31:0] ELS_RST = 32'h0000_0A0A;
  localparam logic [31:0] CMD_RST = 32'h0000_0000;
  localparam logic [31:0] FMAX_RST = 32'h0000_1770;
  localparam logic [31:0] TIME_RST = 32'h0064_0064;
  typedef enum logic [SHAPE_W-1:0] {
    FRS_LINEAR = 3'h0,
    FRS_S = 3'h1,
    FRS_U = 3'h2,
    FRS_INV_U = 3'h3,
    FRS_ELEV = 3'h4
  } frs_shape_t;
  // ---------------------------------------------------------------
  // fixed point, Q16 progress
  // ---------------------------------------------------------------
  localparam logic [16:0] ONE = 17'h1_0000;
  localparam logic [17:0] TWO = 18'h2_0000;
  localparam logic [6:0] RATIO_MAX = 7'h64;
  localparam logic [3:0] CURV_MIN = 4'h1;
  localparam logic [3:0] CURV_MAX = 4'hA;
  localparam logic [16:0] CURV_STEP = 17'h0_199A;
  localparam logic [9:0] PCT_Q16 = 10'h28F;
  localparam logic [4:0] DIV_STEPS = 5'h11;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef struct packed {
    logic [AW-1:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [AW-1:0] araddr;
    logic arvalid;
    logic rready;
  } frs_axi_req_t;
  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } frs_axi_rsp_t;
endpackage

//--- frs_term_model.sv
// terminal and command source model facing the ramp shaper
`timescale 1ns/1ps
module frs_term_model (
  // clock
  input wire logic aclk,
  // settings from the bench
  input wire logic [15:0] cmd_set,
  input wire logic [3:0] speed_set,
  // terminals
  output logic [15:0] freq_cmd_in,
  output logic [3:0] speed_select
);
  // ------------------------------------------
  // terminals
  // ------------------------------------------
  // digital source, changes only at an edge, so no jitter restarts the curve
  always_ff @(posedge aclk)
  begin
    freq_cmd_in <= cmd_set;
    speed_select <= speed_set;
  end
endmodule

//--- frs_ramp_shaper_sva.sv
// port assertions of the frequency ramp shaper
`timescale 1ns/1ps
module frs_ramp_shaper_sva (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire frs_pkg::frs_axi_req_t axi_req,
  input wire frs_pkg::frs_axi_rsp_t axi_rsp,
  // terminals and motor stage
  input wire logic ramp_hold_input,
  input wire logic ramp_bypass_input,
  input wire logic [frs_pkg::FW-1:0] freq_out,
  input wire logic ramping,
  input wire logic decelerating
);
  import frs_pkg::*;
  // ------------------------------------------
  // properties
  // ------------------------------------------
  default clocking frs_cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  AST_W_ANSWER: assert property (axi_req.awvalid && axi_rsp.awready
    && axi_req.wvalid && axi_rsp.wready |=> ##1 axi_rsp.bvalid)
    else $error("write not answered");
  AST_R_ANSWER: assert property (axi_req.arvalid && axi_rsp.arready
    |=> axi_rsp.rvalid)
    else $error("read not answered");
  AST_B_STANDS: assert property ($fell(axi_rsp.bvalid)
    |-> $past(axi_req.bready))
    else $error("write answer dropped early");
  AST_R_STANDS: assert property ($fell(axi_rsp.rvalid)
    |-> $past(axi_req.rready))
    else $error("read answer dropped early");
  AST_B_REFUSE: assert property (axi_rsp.bvalid
    |-> !axi_rsp.awready && !axi_rsp.wready)
    else $error("write taken while answer pending");
  AST_ERR_ZERO: assert property (axi_rsp.rvalid
    && axi_rsp.rresp == RESP_SLVERR |-> axi_rsp.rdata == 32'h0)
    else $error("error read carries data");
  AST_BYP_FOLLOW:
    assert property (ramp_bypass_input |=> !ramping)
    else $error("ramp kept under bypass");
  AST_HOLD_FREEZE:
    assert property ((ramp_hold_input && !ramp_bypass_input) [*3]
    |-> $stable(freq_out))
    else $error("output moved during hold");
  AST_UP_MONO:
    assert property ((ramping && !decelerating && !ramp_bypass_input) [*2]
    |-> freq_out >= $past(freq_out))
    else $error("output fell while accelerating");
endmodule
bind frs_ramp_shaper frs_ramp_shaper_sva frs_ramp_shaper_sva_inst (
  .aclk, .aresetn, .axi_req, .axi_rsp, .ramp_hold_input,
  .ramp_bypass_input, .freq_out, .ramping, .decelerating);

//--- frs_ramp_shaper_test.sv
// self-checking bench of the frequency ramp shaper
`timescale 1ns/1ps
module frs_ramp_shaper_test;
  import frs_pkg::*;
  localparam logic [31:0] ALL = 32'hFFFF_FFFF;
  localparam logic [15:0] TOP = 16'h00C8;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  frs_axi_req_t rq = '0;
  frs_axi_rsp_t rs;
  logic [15:0] cmd_set = 16'h0;
  logic [3:0] speed_set = 4'h0;
  logic hold = 1'b0;
  logic byp = 1'b0;
  logic two = 1'b0;
  logic [6:0] sbits = 7'h00;
  logic [15:0] fcmd;
  logic [3:0] ssel;
  logic [15:0] v;
  logic [15:0] fo;
  logic rmp;
  logic dcl;
  logic [65:0] e;
  logic [65:0] rq_q[$];
  logic [1:0] bq_q[$];
  logic [31:0] rv [8] = '{CTRL_RST, CURVE_RST, ELS_RST, ELS_RST, CMD_RST,
    FMAX_RST, TIME_RST, TIME_RST};
  int n_mismatch = 0;
  int total_checks = 0;
  always #2.5 aclk = ~aclk;
  frs_term_model frs_term_model_inst (.aclk, .cmd_set, .speed_set,
    .freq_cmd_in(fcmd), .speed_select(ssel));
  // time unit shrunk to 20 cycles: 1.0 s of ramp time is 200 cycles
  frs_ramp_shaper #(.TIME_UNIT_CYCLES(20)) frs_ramp_shaper_inst (
    .aclk, .aresetn, .axi_req(rq), .axi_rsp(rs), .freq_cmd_in(fcmd),
    .ramp_hold_input(hold), .ramp_bypass_input(byp),
    .two_stage_input(two), .speed_select(ssel), .speed_bits(sbits),
    .freq_out(fo), .ramping(rmp), .decelerating(dcl));
  // ------------------------------------------
  // reporting and bus tasks
  // ------------------------------------------
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic cmp(input logic [33:0] x, input logic [33:0] g);
    total_checks++;
    if (g !== x)
    begin
      n_mismatch++;
      $display("Error at %0t: exp %h got %h", $time, x, g);
    end
  endtask
  task automatic tmo(input int n);
    if (n > 50)
    begin
      cmp(34'h1, 34'h0);
      stop_test();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] r = RESP_OKAY);
    int n;
    bq_q.push_back(r);
    rq.awaddr <= a;
    rq.wdata <= d;
    rq.wstrb <= 4'hF;
    rq.awvalid <= 1'b1;
    rq.wvalid <= 1'b1;
    rq.bready <= 1'b1;
    n = 0;
    do
    begin
      @(posedge aclk);
      n++;
      if (rq.awvalid && rs.awready)
        rq.awvalid <= 1'b0;
      if (rq.wvalid && rs.wready)
        rq.wvalid <= 1'b0;
      tmo(n);
    end
    while (!rs.bvalid);
    rq.bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x,
      input logic [31:0] m, input logic [1:0] r = RESP_OKAY);
    int n;
    rq_q.push_back({r, m, x & m});
    rq.araddr <= a;
    rq.arvalid <= 1'b1;
    rq.rready <= 1'b1;
    n = 0;
    do
    begin
      @(posedge aclk);
      n++;
      if (rq.arvalid && rs.arready)
        rq.arvalid <= 1'b0;
      tmo(n);
    end
    while (!rs.rvalid);
    rq.rready <= 1'b0;
    @(posedge aclk);
  endtask
  always @(posedge aclk)
  begin
    if (rq.rready && rs.rvalid)
    begin
      e = rq_q.pop_front();
      cmp({e[65:64], e[31:0]}, {rs.rresp, rs.rdata & e[63:32]});
    end
    if (rq.bready && rs.bvalid)
      cmp({bq_q.pop_front(), 32'h0}, {rs.bresp, 32'h0});
  end
  // ------------------------------------------
  // scenarios
  // ------------------------------------------
  initial
  begin
    void'($urandom(32'hE9B28CB6));
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    foreach (rv[i])
      rd(8'(i * 4), rv[i], ALL);
    rd(ADDR_SPD_BASE, TIME_RST, ALL);
    rd(ADDR_STATUS, 32'h0, ALL);
    rd(8'h30, 32'h0, ALL, RESP_SLVERR);
    wr(ADDR_STATUS, 32'h1, RESP_SLVERR);
    $display("test reset and map done");
    for (int k = 0; k < 5; k++)
    begin
      wr(ADDR_CTRL, 32'(k * 17));
      rd(ADDR_CTRL, 32'(k * 17), ALL);
    end
    wr(ADDR_CURVE, 32'h0F00);
    rd(ADDR_CURVE, 32'h0A01, ALL);
    wr(ADDR_ELS_ACC, 32'h5019);
    rd(ADDR_ELS_ACC, 32'h4B19, ALL);
    wr(ADDR_ELS_DEC, 32'h0070);
    rd(ADDR_ELS_DEC, 32'h0064, ALL);
    $display("test shape settings done");
    wr(ADDR_TIME_BASE, 32'h000A_000A);
    byp <= 1'b1;
    for (int s = 0; s < 2; s++)
    begin
      v = 16'($urandom % 6000);
      cmd_set <= v;
      wr(ADDR_CMD, {16'h0, v});
      wr(ADDR_CTRL, 32'h11 | 32'(s << 9));
      rd(ADDR_STATUS, 32'h40000 | 32'(v), 32'h4FFFF);
    end
    byp <= 1'b0;
    repeat (4) @(posedge aclk);
    rd(ADDR_STATUS, 32'(v), 32'h5FFFF);
    byp <= 1'b1;
    cmd_set <= 16'h0;
    repeat (4) @(posedge aclk);
    byp <= 1'b0;
    $display("test bypass done");
    // one step per cycle at most, so fmax must not exceed time * unit
    wr(ADDR_FMAX, 32'(TOP));
    for (int k = 0; k < 5; k++)
    begin
      wr(ADDR_CTRL, 32'h200 | 32'(k * 17));
      cmd_set <= TOP;
      repeat (150) @(posedge aclk);
      rd(ADDR_STATUS, 32'h10000, 32'h90000);
      repeat (80) @(posedge aclk);
      rd(ADDR_STATUS, 32'(TOP), 32'h1FFFF);
      cmp(34'(TOP), {rmp, dcl, 16'h0, fo});
      cmd_set <= 16'h0;
      repeat (100) @(posedge aclk);
      rd(ADDR_STATUS, 32'h90000, 32'h90000);
      cmp(34'h3_0000_0000, {rmp, dcl, 32'h0});
      repeat (130) @(posedge aclk);
      rd(ADDR_STATUS, 32'h0, 32'h1FFFF);
    end
    $display("test ramp time done");
    cmd_set <= TOP;
    repeat (60) @(posedge aclk);
    hold <= 1'b1;
    repeat (300) @(posedge aclk);
    rd(ADDR_STATUS, 32'h20000, 32'h20000);
    hold <= 1'b0;
    repeat (260) @(posedge aclk);
    rd(ADDR_STATUS, 32'(TOP), 32'h3FFFF);
    $display("test hold done");
    wr(ADDR_SPD_BASE + 8'h0C, 32'h0);
    wr(ADDR_TIME_ALT, 32'h0);
    wr(ADDR_CTRL, 32'h311);
    two <= 1'b1;
    speed_set <= 4'h3;
    v = 16'($urandom % TOP);
    cmd_set <= v;
    repeat (4) @(posedge aclk);
    rd(ADDR_STATUS, 32'(v), 32'hFFFF);
    speed_set <= 4'h0;
    cmd_set <= TOP;
    repeat (4) @(posedge aclk);
    rd(ADDR_STATUS, 32'h10000, 32'h10000);
    wr(ADDR_CTRL, 32'h711);
    sbits <= 7'h04;
    repeat (4) @(posedge aclk);
    rd(ADDR_STATUS, 32'(TOP), 32'hFFFF);
    wr(ADDR_CTRL, 32'h211);
    cmd_set <= v;
    repeat (4) @(posedge aclk);
    rd(ADDR_STATUS, 32'(v), 32'hFFFF);
    $display("test multi-speed done");
    stop_test();
  end
endmodule
